//--- rtl/sasr_readout.sv
// conversion control and serial readout of the six-channel sampling converter
// How it works
// - pin mode: span pin sampled at busy fall, high narrow, low wide span
// - after reset the pin span takes effect only at first busy fall
// - register mode: each pair span from its own control bit, 1 narrow
// - rising pair strobe starts conversion; busy rises after that edge
// - busy falls after 3 us, then new results load for readout
// - lane enable pins choose which of the three output lanes drive
// - two lanes: lane A carries 1,2,5, lane B carries 3,4,6
// - one lane carries all six results in 96, 32 or 16 clock frames
// - three lanes deliver results in one 32 or two 16 clock frames
// - chip select fall releases lanes and shows first result MSB
// - sixteen-bit words MSB first, short variants lead with zeros
// - later bits change on rising clock, host samples on falling
// - chain enable turns three data pins into chain inputs for lanes
// - two-lane chain sends own words then forwards upstream words
// - three-lane chain: own 32 clocks, then 32 forwarded clocks
// - chained reads may use 16 clock frames while chain stays enabled
// - strobe low before busy falls powers that pair down
// - standby input low holds whole device in standby
// - readout keeps working during standby
// - register mode: pick bits choose pairs, strobe A starts them
// - results go out in ascending channel order
`timescale 1ns/1ns
module sasr_readout
  import sasr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // conversion pins
  input wire logic [NPAIR-1:0] pair_start_strobe,
  input wire logic standby_input,
  input wire logic sel_source_pin,
  input wire logic range_pin,
  // control word write, same clock
  input wire sasr_ctrl_s ctrl_word,
  input wire logic ctrl_write,
  // converter core samples, same clock
  input wire logic [NCH-1:0][WORD_W-1:0] sample_word,
  // status
  output logic busy,
  output logic [NPAIR-1:0] active_span,
  output logic [NPAIR-1:0] convert_pairs,
  output logic [NPAIR-1:0] pair_powerdown,
  output logic device_standby,
  // interface straps
  input wire logic interface_style_pin,
  input wire logic chain_enable_pin,
  input wire logic [2:0] lane_enable_pin,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [2:0] chain_input_lane,
  output logic [2:0] dout_lane,
  output logic [2:0] dout_lane_oe_n
);

  // pin synchronisers
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [NPAIR-1:0] strobe_prev_reg;
  logic [NPAIR-1:0] strobe_now;
  logic [NPAIR-1:0] strobe_rise;
  logic standby_now;
  logic sel_now;
  logic range_now;
  logic serial_now;
  logic chain_now;
  logic [2:0] lane_en_now;

  // conversion control
  sasr_conv_e state_reg;
  sasr_conv_e state_next;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic busy_reg;
  logic [NPAIR-1:0] start_pairs;
  logic start_ok;
  logic conv_done;
  logic [NPAIR-1:0] conv_pairs_reg;
  sasr_ctrl_s ctrl_reg;
  logic [NPAIR-1:0] span_reg;
  logic [NPAIR-1:0] pd_reg;
  logic standby_reg;
  logic link_clear_reg;

  // result storage
  logic [NCH-1:0][WORD_W-1:0] hold_reg;
  logic [NCH-1:0][WORD_W-1:0] list_reg;
  logic [NCH-1:0][WORD_W-1:0] list_next;
  int fill;
  sasr_mode_s mode_reg;
  sasr_mode_s mode_next;

  // link side
  logic [BIT_W-1:0] bit_idx_reg;
  logic started_reg;
  logic [PTR_W-1:0] word_ptr_reg;
  logic [PTR_W-1:0] slots;
  logic [2:0] lane_on;
  logic [BUF_BITS-1:0] chain_buf_reg [3];

  // two-stage capture of every asynchronous pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_reg <= PIN_RESET;
      pin_sync_reg <= PIN_RESET;
    end else begin
      pin_meta_reg <= {lane_enable_pin, chain_enable_pin, interface_style_pin,
                       range_pin, sel_source_pin, standby_input, pair_start_strobe};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign strobe_now = pin_sync_reg[2:0];
  assign standby_now = pin_sync_reg[3];
  assign sel_now = pin_sync_reg[4];
  assign range_now = pin_sync_reg[5];
  assign serial_now = pin_sync_reg[6];
  assign chain_now = pin_sync_reg[7];
  assign lane_en_now = pin_sync_reg[10:8];

  always_ff @(posedge mclk) begin
    if (reset) begin
      strobe_prev_reg <= '0;
    end else begin
      strobe_prev_reg <= strobe_now;
    end
  end

  assign strobe_rise = strobe_now & ~strobe_prev_reg;

  // pair choice: strobes directly, or pick bits started by strobe A
  always_comb begin
    if (sel_now) begin
      start_pairs = strobe_rise[0] ? ctrl_reg.pick : '0;
    end else begin
      start_pairs = strobe_rise;
    end
  end

  assign start_ok = (state_reg == SASR_IDLE) && standby_reg == 1'b0 && (|start_pairs);
  assign conv_done = (state_reg == SASR_CONV) && (conv_cnt_reg == CONV_LAST);

  // control word
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= ctrl_word;
    end
  end

  // conversion state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SASR_IDLE: begin
        if (start_ok) begin
          state_next = SASR_CONV;
        end
      end
      SASR_CONV: begin
        if (conv_done) begin
          state_next = SASR_IDLE;
        end
      end
      default: begin
        state_next = SASR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= SASR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_cnt_reg <= '0;
    end else if (state_reg == SASR_CONV && !conv_done) begin
      conv_cnt_reg <= conv_cnt_reg + 1'b1;
    end else begin
      conv_cnt_reg <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else if (start_ok) begin
      busy_reg <= 1'b1;
    end else if (conv_done) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_pairs_reg <= '0;
    end else if (start_ok) begin
      conv_pairs_reg <= start_pairs;
    end
  end

  // link pointers held clear while a conversion runs
  always_ff @(posedge mclk) begin
    if (reset) begin
      link_clear_reg <= 1'b1;
    end else begin
      link_clear_reg <= start_ok || (state_reg == SASR_CONV && !conv_done);
    end
  end

  // span in force for the next conversion
  always_ff @(posedge mclk) begin
    if (reset) begin
      span_reg <= SPAN_RESET;
    end else if (sel_now) begin
      span_reg <= ctrl_reg.span;
    end else if (conv_done) begin
      span_reg <= {NPAIR{range_now}};
    end
  end

  // whole-device standby
  always_ff @(posedge mclk) begin
    if (reset) begin
      standby_reg <= 1'b0;
    end else begin
      standby_reg <= ~standby_now;
    end
  end

  // per pair power-down and sample capture
  genvar gp;
  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_pair
      always_ff @(posedge mclk) begin
        if (reset) begin
          pd_reg[gp] <= PD_RESET[gp];
        end else if (conv_done && conv_pairs_reg[gp] && !strobe_now[gp]) begin
          pd_reg[gp] <= 1'b1;
        end else if (strobe_now[gp]) begin
          pd_reg[gp] <= 1'b0;
        end
      end

      always_ff @(posedge mclk) begin
        if (reset) begin
          hold_reg[2*gp] <= '0;
          hold_reg[2*gp+1] <= '0;
        end else if (start_ok && start_pairs[gp]) begin
          hold_reg[2*gp] <= sample_word[2*gp] & RES_MASK;
          hold_reg[2*gp+1] <= sample_word[2*gp+1] & RES_MASK;
        end
      end
    end
  endgenerate

  // converted channels packed in ascending order
  always_comb begin
    fill = 0;
    list_next = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      if (conv_pairs_reg[ch/2]) begin
        list_next[fill] = hold_reg[ch];
        fill = fill + 1;
      end
    end
  end

  always_comb begin
    mode_next.serial = serial_now;
    mode_next.chain = chain_now && serial_now;
    if (lane_en_now == LANE_THREE_MASK) begin
      mode_next.lanes = SASR_LANE_THREE;
    end else if (lane_en_now == LANE_TWO_MASK) begin
      mode_next.lanes = SASR_LANE_TWO;
    end else begin
      mode_next.lanes = SASR_LANE_ONE;
    end
  end

  // results and mode frozen at busy fall
  always_ff @(posedge mclk) begin
    if (reset) begin
      list_reg <= '0;
      mode_reg <= MODE_RESET;
    end else if (conv_done) begin
      list_reg <= list_next;
      mode_reg <= mode_next;
    end
  end

  assign busy = busy_reg;
  assign active_span = span_reg;
  assign convert_pairs = conv_pairs_reg;
  assign pair_powerdown = pd_reg;
  assign device_standby = standby_reg;

  // link clock domain: list_reg and mode_reg stay constant while clear is low

  // bit within word, restarts on every frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_reg <= 1'b0;
      bit_idx_reg <= '0;
    end else if (!started_reg) begin
      started_reg <= 1'b1;
    end else begin
      bit_idx_reg <= bit_idx_reg + 1'b1;
    end
  end

  // next pending word; a partly read word is sent again
  always_ff @(negedge sclk or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      word_ptr_reg <= '0;
    end else if (!cs_n && started_reg && bit_idx_reg == BIT_LAST) begin
      word_ptr_reg <= word_ptr_reg + 1'b1;
    end
  end

  always_comb begin
    case (mode_reg.lanes)
      SASR_LANE_THREE: begin
        slots = SLOTS_THREE;
        lane_on = LANE_THREE_MASK;
      end
      SASR_LANE_TWO: begin
        slots = SLOTS_TWO;
        lane_on = LANE_TWO_MASK;
      end
      default: begin
        slots = SLOTS_ONE;
        lane_on = LANE_ONE_MASK;
      end
    endcase
  end

  function automatic logic [2:0] own_index(input sasr_lanes_e lanes, input int lane,
                                           input logic [PTR_W-1:0] slot);
    case (lanes)
      SASR_LANE_THREE: own_index = 3'(2 * lane + int'(slot));
      SASR_LANE_TWO: own_index = (slot < 7'h02) ? 3'(2 * lane + int'(slot))
                                               : 3'(4 + lane);
      default: own_index = slot[2:0];
    endcase
  endfunction

  genvar gl;
  generate
    for (gl = 0; gl < 3; gl++) begin : g_lane
      logic [RING_W-1:0] ring;
      logic own;
      logic [WORD_W-1:0] own_word;
      logic bit_val;

      assign ring = RING_W'((int'(word_ptr_reg) % int'(slots)) * WORD_W + int'(bit_idx_reg));
      assign own = word_ptr_reg < slots;
      assign own_word = list_reg[own_index(mode_reg.lanes, gl, word_ptr_reg)];

      // upstream bits delayed by this device's own frame length
      always_ff @(negedge sclk) begin
        if (!cs_n && mode_reg.chain) begin
          chain_buf_reg[gl][ring] <= chain_input_lane[gl];
        end
      end

      always_comb begin
        if (own) begin
          bit_val = own_word[BIT_LAST - bit_idx_reg];
        end else if (mode_reg.chain) begin
          bit_val = chain_buf_reg[gl][ring];
        end else begin
          bit_val = 1'b0;
        end
      end

      assign dout_lane[gl] = bit_val & lane_on[gl] & mode_reg.serial;
      assign dout_lane_oe_n[gl] = cs_n | ~lane_on[gl] | ~mode_reg.serial;
    end
  endgenerate

endmodule

//--- rtl/sasr_pkg.sv
// shared constants and types for the six-channel serial readout block
package sasr_pkg;
  localparam int NPAIR = 3;
  localparam int NCH = 6;
  localparam int WORD_W = 16;
  localparam int RES_BITS = 16;
  localparam logic [WORD_W-1:0] RES_MASK = WORD_W'((1 << RES_BITS) - 1);
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam int PTR_W = 7;
  localparam int BIT_W = 4;
  localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;
  localparam int BUF_BITS = NCH * WORD_W;
  localparam int RING_W = 7;
  localparam int PIN_W = 11;
  localparam logic [PIN_W-1:0] PIN_RESET = 11'h000;
  localparam logic [2:0] SPAN_RESET = 3'h0;
  localparam logic [2:0] PD_RESET = 3'h0;
  localparam logic [2:0] LANE_ONE_MASK = 3'h1;
  localparam logic [2:0] LANE_TWO_MASK = 3'h3;
  localparam logic [2:0] LANE_THREE_MASK = 3'h7;
  localparam logic [PTR_W-1:0] SLOTS_ONE = 7'h06;
  localparam logic [PTR_W-1:0] SLOTS_TWO = 7'h03;
  localparam logic [PTR_W-1:0] SLOTS_THREE = 7'h02;

  // control word as written on data bits 15..8
  typedef struct packed {
    logic [2:0] pick;
    logic [2:0] span;
    logic ref_internal;
    logic ref_bypass;
  } sasr_ctrl_s;
  localparam sasr_ctrl_s CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    SASR_LANE_ONE = 2'b00,
    SASR_LANE_TWO = 2'b01,
    SASR_LANE_THREE = 2'b10
  } sasr_lanes_e;

  typedef enum logic {
    SASR_IDLE = 1'b0,
    SASR_CONV = 1'b1
  } sasr_conv_e;

  // readout mode frozen at the end of each conversion
  typedef struct packed {
    sasr_lanes_e lanes;
    logic chain;
    logic serial;
  } sasr_mode_s;
  localparam sasr_mode_s MODE_RESET = 4'h0;
endpackage

//--- tb/sasr_host_model.sv
// host serial reader with an upstream chain device on the chain inputs
`timescale 1ns/1ns
module sasr_host_model (
  // link clock and frame
  output logic sclk,
  output logic cs_n,
  // upstream chain data
  output logic [2:0] chain_input_lane,
  // lane data from the block
  input wire logic [2:0] dout_lane
);
  logic [2:0][15:0] sh;
  logic [2:0][15:0] cap;
  int upos = 0;
  event got;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    chain_input_lane = 3'h5;
  end
  function automatic logic [15:0] up_word(int l, int s);
    return 16'hC000 | 16'(l << 8) | 16'(s);
  endfunction
  function automatic logic [2:0] up_bits(int p, int ucnt);
    logic [2:0] b;
    logic [15:0] w;
    for (int l = 0; l < 3; l++) begin
      w = up_word(l, p / 16);
      b[l] = (p / 16 < ucnt) ? w[15 - p % 16] : 1'b0;
    end
    return b;
  endfunction
  // one frame of n clocks; clock stands low outside frames
  task automatic frame(int n, bit first, int ucnt, bit slow);
    int k;
    k = 0;
    upos = first ? 0 : upos / 16 * 16;
    cs_n = 1'b0;
    chain_input_lane = up_bits(upos, ucnt);
    #3;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      if (i > 0) chain_input_lane = up_bits(upos + i, ucnt);
      #3;
      for (int l = 0; l < 3; l++) sh[l] = {sh[l][14:0], dout_lane[l]};
      sclk = 1'b0;
      k++;
      if (k % 16 == 0) begin
        cap = sh;
        ->got;
      end
      #3;
      if (slow && k % 16 == 0) #30;
    end
    upos = upos + n;
    cs_n = 1'b1;
    chain_input_lane = ~chain_input_lane;
    #3;
  endtask
endmodule

//--- tb/sasr_readout_asserts.sv
// concurrent checks on the ports of the serial readout block
`timescale 1ns/1ns
module sasr_readout_asserts
  import sasr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // conversion pins
  input wire logic [NPAIR-1:0] pair_start_strobe,
  input wire logic standby_input,
  input wire logic sel_source_pin,
  input wire logic range_pin,
  input wire sasr_ctrl_s ctrl_word,
  input wire logic ctrl_write,
  // status
  input wire logic busy,
  input wire logic [NPAIR-1:0] active_span,
  input wire logic [NPAIR-1:0] convert_pairs,
  input wire logic [NPAIR-1:0] pair_powerdown,
  input wire logic device_standby,
  // link
  input wire logic interface_style_pin,
  input wire logic [2:0] lane_enable_pin,
  input wire logic cs_n,
  input wire logic [2:0] dout_lane_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [5:0] busy_cnt;
  logic [2:0] lane_mask;
  always_ff @(posedge mclk) begin
    if (reset || !busy) begin
      busy_cnt <= 6'h00;
    end else begin
      busy_cnt <= busy_cnt + 6'h01;
    end
  end
  assign lane_mask = (lane_enable_pin == 3'h7) ? 3'h7 :
                     ((lane_enable_pin == 3'h3) ? 3'h3 : 3'h1);
  property p_busy_len;
    $fell(busy) |-> busy_cnt == 6'h1E;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
  property p_start;
    !busy && !device_standby && !sel_source_pin && $rose(pair_start_strobe[0]) |-> ##[2:5] busy;
  endproperty
  a_start: assert property (p_start) else $error("strobe did not start");
  property p_refuse;
    device_standby [*3] |-> !$rose(busy);
  endproperty
  a_refuse: assert property (p_refuse) else $error("start in standby");
  property p_standby_input;
    !standby_input [*4] |-> device_standby;
  endproperty
  a_standby_input: assert property (p_standby_input) else $error("standby not entered");
  property p_span_pin;
    $fell(busy) && !sel_source_pin |=> active_span == {3{range_pin}};
  endproperty
  a_span_pin: assert property (p_span_pin) else $error("pin span wrong");
  property p_span_hold;
    !sel_source_pin && !busy && !$fell(busy) |=> $stable(active_span);
  endproperty
  a_span_hold: assert property (p_span_hold) else $error("span moved");
  property p_span_reg;
    sel_source_pin && ctrl_write |-> ##[1:4] active_span == ctrl_word.span;
  endproperty
  a_span_reg: assert property (p_span_reg) else $error("word span wrong");
  property p_pd;
    $fell(busy) |=> (pair_powerdown & convert_pairs) == (convert_pairs & ~pair_start_strobe);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down wrong");
  property p_float;
    cs_n |-> dout_lane_oe_n == 3'h7;
  endproperty
  a_float: assert property (p_float) else $error("lane driven idle");
  property p_lanes;
    !cs_n |-> dout_lane_oe_n == (interface_style_pin ? ~lane_mask : 3'h7);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane enable wrong");
  c_done: cover property ($fell(busy));
  c_frame: cover property ($fell(cs_n));
  c_pd: cover property (pair_powerdown != 3'h0);
endmodule
bind sasr_readout sasr_readout_asserts i_chk (.mclk(mclk), .reset(reset),
  .pair_start_strobe(pair_start_strobe), .standby_input(standby_input),
  .sel_source_pin(sel_source_pin), .range_pin(range_pin), .ctrl_word(ctrl_word),
  .ctrl_write(ctrl_write), .busy(busy), .active_span(active_span),
  .convert_pairs(convert_pairs), .pair_powerdown(pair_powerdown),
  .device_standby(device_standby), .interface_style_pin(interface_style_pin),
  .lane_enable_pin(lane_enable_pin), .cs_n(cs_n),
  .dout_lane_oe_n(dout_lane_oe_n));

//--- tb/tb_sasr_readout.sv
// self-checking bench for the six-channel serial readout block
`timescale 1ns/1ns
module tb_sasr_readout;
  import sasr_pkg::*;
  localparam logic [2:0] LT[5] = '{3'h1, 3'h1, 3'h3, 3'h7, 3'h7};
  localparam int LN[5] = '{1, 1, 2, 3, 3};
  localparam int FB[5] = '{32, 16, 48, 32, 16};
  localparam int NF[5] = '{3, 6, 1, 1, 2};
  logic mclk, reset, standby_input, sel_source_pin, range_pin, ctrl_write;
  logic busy, device_standby, chain_enable_pin, sclk, cs_n, interface_style_pin;
  logic [NPAIR-1:0] pair_start_strobe, active_span, convert_pairs, pair_powerdown;
  logic [2:0] lane_enable_pin, chain_input_lane, dout_lane, dout_lane_oe_n;
  sasr_ctrl_s ctrl_word;
  logic [NCH-1:0][WORD_W-1:0] sample_word;
  logic [WORD_W-1:0] q[$];
  logic [WORD_W-1:0] list[NCH];
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int nl = 0;
  int nw = 0;
  sasr_readout i_dut (
    .mclk, .reset, .pair_start_strobe, .standby_input, .sel_source_pin, .range_pin,
    .ctrl_word, .ctrl_write, .sample_word, .busy, .active_span, .convert_pairs,
    .pair_powerdown, .device_standby, .interface_style_pin,
    .chain_enable_pin, .lane_enable_pin, .sclk, .cs_n, .chain_input_lane, .dout_lane,
    .dout_lane_oe_n
  );
  sasr_host_model i_host (.sclk, .cs_n, .chain_input_lane, .dout_lane);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic waitb(logic v);
    int k;
    k = 0;
    while (busy !== v && k < 50) begin
      step(1);
      k++;
    end
    chk("busy", 16'(busy), 16'(v));
  endtask
  // convert pairs p with strobes s; keep holds strobes up past busy fall
  task automatic conv(logic [2:0] s, logic [2:0] p, bit keep);
    for (int c = 0; c < NCH; c++) sample_word[c] = 16'($urandom);
    nw = 0;
    for (int c = 0; c < NCH; c++) begin
      if (p[c / 2]) begin
        list[nw] = sample_word[c];
        nw++;
      end
    end
    pair_start_strobe = s;
    waitb(1'b1);
    chk("pairs", 16'(convert_pairs), 16'(p));
    if (!keep) pair_start_strobe = 3'h0;
    waitb(1'b0);
    step(4);
    chk("powerdown", 16'(pair_powerdown & p), 16'(keep ? p & ~s : p));
    pair_start_strobe = 3'h0;
    step(3);
  endtask
  // note expected words per slot and lane, then read in nf frames of fb clocks
  task automatic rd(int lanes, int fb, int nf, bit ch, bit slow);
    int own;
    int k;
    nl = lanes;
    own = 6 / lanes;
    for (int s = 0; s < nf * fb / 16; s++) begin
      for (int l = 0; l < lanes; l++) begin
        k = (lanes == 2 && s == 2) ? 4 + l : (lanes == 1 ? s : l * 2 + s);
        if (s >= own) q.push_back(ch ? i_host.up_word(l, s - own) : 16'h0000);
        else q.push_back(k < nw ? list[k] : 16'h0000);
      end
    end
    #($urandom_range(1, 40));
    for (int f = 0; f < nf; f++) i_host.frame(fb, f == 0, ch ? own : 0, slow);
    step(2);
    chk("drained", 16'(q.size()), 16'h0000);
  endtask
  initial begin
    forever begin
      @(i_host.got);
      for (int l = 0; l < nl; l++) begin
        if (q.size() == 0) chk("extra word", 16'h0001, 16'h0000);
        else chk("lane word", i_host.cap[l], q.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(24872));
    reset = 1'b1;
    pair_start_strobe = 3'h0;
    standby_input = 1'b1;
    sel_source_pin = 1'b0;
    range_pin = 1'b1;
    ctrl_write = 1'b0;
    ctrl_word = CTRL_RESET;
    sample_word = '0;
    chain_enable_pin = 1'b0;
    lane_enable_pin = 3'h1;
    interface_style_pin = 1'b1;
    step(5);
    reset = 1'b0;
    step(3);
    chk("span reset", 16'(active_span), 16'h0000);
    conv(3'h7, 3'h7, 1'b1);
    chk("span high", 16'(active_span), 16'h0007);
    rd(1, 96, 1, 1'b0, 1'b0);
    for (int t = 0; t < 5; t++) begin
      lane_enable_pin = LT[t];
      range_pin = 1'(t % 2);
      conv(3'h7, 3'h7, 1'b1);
      chk("span pin", 16'(active_span), t % 2 == 1 ? 16'h0007 : 16'h0000);
      rd(LN[t], FB[t], NF[t], 1'b0, t == 2);
    end
    lane_enable_pin = 3'h1;
    conv(3'h2, 3'h2, 1'b0);
    i_host.frame(8, 1'b1, 0, 1'b0);
    rd(1, 96, 1, 1'b0, 1'b1);
    pair_start_strobe = 3'h7;
    step(45);
    chk("woken", 16'(pair_powerdown), 16'h0000);
    pair_start_strobe = 3'h0;
    step(3);
    interface_style_pin = 1'b0;
    conv(3'h1, 3'h1, 1'b1);
    nl = 1;
    q.push_back(16'h0000);
    i_host.frame(16, 1'b1, 0, 1'b0);
    step(2);
    chk("quiet", 16'(q.size()), 16'h0000);
    interface_style_pin = 1'b1;
    chain_enable_pin = 1'b1;
    lane_enable_pin = 3'h3;
    conv(3'h7, 3'h7, 1'b1);
    rd(2, 96, 1, 1'b1, 1'b0);
    conv(3'h7, 3'h7, 1'b1);
    rd(2, 16, 6, 1'b1, 1'b0);
    lane_enable_pin = 3'h7;
    conv(3'h7, 3'h7, 1'b1);
    rd(3, 64, 1, 1'b1, 1'b0);
    chain_enable_pin = 1'b0;
    lane_enable_pin = 3'h1;
    conv(3'h7, 3'h7, 1'b1);
    standby_input = 1'b0;
    step(5);
    chk("standby", 16'(device_standby), 16'h0001);
    pair_start_strobe = 3'h1;
    step(10);
    chk("refused", 16'(busy), 16'h0000);
    pair_start_strobe = 3'h0;
    rd(1, 96, 1, 1'b0, 1'b0);
    standby_input = 1'b1;
    step(5);
    chk("awake", 16'(device_standby), 16'h0000);
    sel_source_pin = 1'b1;
    ctrl_word = 8'hA9;
    step(3);
    ctrl_write = 1'b1;
    step(1);
    ctrl_write = 1'b0;
    step(5);
    chk("span word", 16'(active_span), 16'h0002);
    conv(3'h1, 3'h5, 1'b1);
    rd(1, 96, 1, 1'b0, 1'b0);
    results();
  end
endmodule
